// ===== common/bsid_pkg.sv
// Shared constants and types for the boundary-scan instruction decode block
package bsid_pkg;
    localparam int IR_WIDTH = 4;
    localparam int ID_WIDTH = 32;
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_SAMPLE = 4'h1;
    localparam logic [3:0] OP_IDCODE = 4'h2;
    localparam logic [3:0] OP_HIGHZ = 4'h3;
    localparam logic [3:0] OP_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // Identification field defaults, values arbitrary
    localparam logic [3:0] ID_VERSION = 4'h0;
    localparam logic [15:0] ID_PART = 16'h0001;
    localparam logic [10:0] ID_MAKER = 11'h001;
    localparam int TCK_DIV = 1;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } bsid_tap_t;
    typedef enum logic [1:0] {PATH_BSR, PATH_ID, PATH_BYP} bsid_path_t;
endpackage : bsid_pkg

// ===== common/bsid_ctl_if.sv
// Carrier between TAP sequencer and instruction decoder
`timescale 1ns/10ps
interface bsid_ctl_if;
    import bsid_pkg::*;
    bsid_tap_t state;
    logic tckRise;
    logic tckFall;
    logic tdi;
    modport tap (output state, output tckRise, output tckFall, output tdi);
    modport dec (input state, input tckRise, input tckFall, input tdi);
endinterface : bsid_ctl_if

// ===== rtl/bsid_tap_fsm.sv
// TAP state sequencer running on sampled link clock edges
`timescale 1ns/10ps
module bsid_tap_fsm (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tckPin,
    input wire logic tmsPin,
    input wire logic tdiPin,
    input wire logic trstPin_n,
    bsid_ctl_if.tap ctl
);
    import bsid_pkg::*;
    logic [2:0] tckSync_q, tckSync_d;
    logic [1:0] tmsSync_q, tmsSync_d;
    logic [1:0] tdiSync_q, tdiSync_d;
    logic [1:0] trstSync_q, trstSync_d;
    bsid_tap_t state_q, state_d;
    logic rise, fall;

    always_comb begin
        tckSync_d = {tckSync_q[1:0], tckPin};
        tmsSync_d = {tmsSync_q[0], tmsPin};
        tdiSync_d = {tdiSync_q[0], tdiPin};
        trstSync_d = {trstSync_q[0], trstPin_n};
        // Stages 1 and 2 only feed the edge compare, stage 0 is left alone
        rise = tckSync_q[1] && !tckSync_q[2];
        fall = !tckSync_q[1] && tckSync_q[2];
        state_d = state_q;
        if (!trstSync_q[1]) begin
            state_d = TAP_RESET; // R16
        end else if (rise) begin
            unique case (state_q) // R16
                TAP_RESET: state_d = tmsSync_q[1] ? TAP_RESET : TAP_IDLE;
                TAP_IDLE: state_d = tmsSync_q[1] ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: state_d = tmsSync_q[1] ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: state_d = tmsSync_q[1] ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR: state_d = tmsSync_q[1] ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: state_d = tmsSync_q[1] ? TAP_UPD_DR : TAP_PAU_DR;
                TAP_PAU_DR: state_d = tmsSync_q[1] ? TAP_EX2_DR : TAP_PAU_DR;
                TAP_EX2_DR: state_d = tmsSync_q[1] ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: state_d = tmsSync_q[1] ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: state_d = tmsSync_q[1] ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR: state_d = tmsSync_q[1] ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR: state_d = tmsSync_q[1] ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: state_d = tmsSync_q[1] ? TAP_UPD_IR : TAP_PAU_IR;
                TAP_PAU_IR: state_d = tmsSync_q[1] ? TAP_EX2_IR : TAP_PAU_IR;
                TAP_EX2_IR: state_d = tmsSync_q[1] ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: state_d = tmsSync_q[1] ? TAP_SEL_DR : TAP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tckSync_q <= 3'h0;
            tmsSync_q <= 2'h3;
            tdiSync_q <= 2'h0;
            trstSync_q <= 2'h0;
            state_q <= TAP_RESET;
        end else begin
            tckSync_q <= tckSync_d;
            tmsSync_q <= tmsSync_d;
            tdiSync_q <= tdiSync_d;
            trstSync_q <= trstSync_d;
            state_q <= state_d;
        end
    end

    assign ctl.state = state_q;
    assign ctl.tckRise = rise;
    assign ctl.tckFall = fall;
    assign ctl.tdi = tdiSync_q[1];
endmodule : bsid_tap_fsm

// ===== rtl/bsid_boundary.sv
// Boundary-scan cell chain with capture, shift and update stages
`timescale 1ns/10ps
module bsid_boundary #(
    parameter int N_OUT = 8,
    parameter int N_IN = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic serIn,
    input wire logic [N_IN-1:0] pinIn,
    input wire logic [N_OUT-1:0] coreOut,
    output logic serOut,
    output logic [N_OUT-1:0] updVal
);
    localparam int LEN = N_OUT + N_IN;
    logic [LEN-1:0] chain_q, chain_d;
    logic [N_OUT-1:0] upd_q, upd_d;

    always_comb begin
        chain_d = chain_q;
        upd_d = upd_q;
        if (capture) begin
            chain_d = {coreOut, pinIn}; // R4 R7
        end else if (shift) begin
            chain_d = {serIn, chain_q[LEN-1:1]};
        end
        // Update stage holds preload values until EXTEST uses them
        if (update) begin
            upd_d = chain_q[LEN-1:N_IN]; // R8
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_q <= '0;
            upd_q <= '0;
        end else begin
            chain_q <= chain_d;
            upd_q <= upd_d;
        end
    end

    assign serOut = chain_q[0];
    assign updVal = upd_q;
endmodule : bsid_boundary

// ===== rtl/bsid_scan_top.sv
// Boundary-scan instruction register, decoder and data register paths
// Function
// R1 - Four-bit instruction register; decoded value selects the data path.
// R2 - Instruction bits shift in from TDI only in Shift-IR.
// R3 - Opcode 0 is external test: boundary register path, pins off core.
// R4 - External test drives pins from boundary cells, captures pin inputs.
// R5 - Opcode 2 selects 32-bit identification register; function undisturbed.
// R6 - After TAP reset the identification register is the default path.
// R7 - Opcode 1 samples functional pin values through boundary register.
// R8 - Sample/preload shifted data is retained as preload for external test.
// R9 - Opcode 3 floats all outputs and selects the bypass stage.
// R10 - Opcode F selects one-bit bypass, one clock of delay.
// R11 - Bypass stage loads zero in Capture-DR.
// R12 - Capture-IR loads a pattern ending in binary 01.
// R13 - Instruction becomes current on falling TCK in Update-IR.
// R14 - Identification: version 31:28, part 27:12, maker 11:1, bit0 one.
// R15 - Unassigned opcodes act as bypass.
// R16 - Five TMS-high clocks or test reset enter Test-Logic-Reset.
`timescale 1ns/10ps
module bsid_scan_top #(
    parameter int N_OUT = 8,
    parameter int N_IN = 8,
    parameter logic [3:0] VERSION = bsid_pkg::ID_VERSION,
    parameter logic [15:0] PART = bsid_pkg::ID_PART,
    parameter logic [10:0] MAKER = bsid_pkg::ID_MAKER
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic [N_OUT-1:0] coreOut,
    input wire logic [N_OUT-1:0] coreOe,
    input wire logic [N_IN-1:0] pinIn,
    output logic tdo,
    output logic tdoOe,
    output logic [N_OUT-1:0] pinOut,
    output logic [N_OUT-1:0] pinOe,
    output logic [N_IN-1:0] coreIn,
    output logic [bsid_pkg::IR_WIDTH-1:0] curInstr
);
    import bsid_pkg::*;
    bsid_ctl_if ctl();

    logic [IR_WIDTH-1:0] irShift_q, irShift_d;
    logic [IR_WIDTH-1:0] irLatch_q, irLatch_d;
    logic [ID_WIDTH-1:0] idShift_q, idShift_d;
    logic bypass_q, bypass_d;
    logic tdo_q, tdo_d;
    logic tdoOe_q, tdoOe_d;
    logic [N_OUT-1:0] pinOut_q, pinOut_d;
    logic [N_OUT-1:0] pinOe_q, pinOe_d;
    logic [N_IN-1:0] coreIn_q, coreIn_d;
    logic [N_IN-1:0] pinSync1_q, pinSync1_d;
    logic [N_IN-1:0] pinSync2_q, pinSync2_d;
    bsid_path_t path;
    logic extest, highz;
    logic capIr, shIr, updIr;
    logic capDr, shDr, updDr;
    logic bsrCap, bsrShift, bsrUpdate;
    logic shifting;
    logic pathData;
    logic bsrSer;
    logic [N_OUT-1:0] bsrUpd;
    logic [ID_WIDTH-1:0] idValue;

    bsid_tap_fsm u_tap (
        .clk(clk),
        .arst_n(arst_n),
        .tckPin(tck),
        .tmsPin(tms),
        .tdiPin(tdi),
        .trstPin_n(trst_n),
        .ctl(ctl)
    );

    assign idValue = {VERSION, PART, MAKER, 1'b1}; // R14

    // Decode of the current instruction
    always_comb begin
        extest = 1'b0;
        highz = 1'b0;
        unique case (irLatch_q) // R1
            OP_EXTEST: begin
                path = PATH_BSR; // R3
                extest = 1'b1;
            end
            OP_SAMPLE: path = PATH_BSR; // R7
            OP_IDCODE: path = PATH_ID; // R5
            OP_HIGHZ: begin
                path = PATH_BYP; // R9
                highz = 1'b1;
            end
            OP_BYPASS: path = PATH_BYP; // R10
            default: path = PATH_BYP; // R15
        endcase
    end

    // Captures and shifts act on rising test clock, updates on falling
    assign capIr = ctl.tckRise && ctl.state == TAP_CAP_IR;
    assign shIr = ctl.tckRise && ctl.state == TAP_SH_IR;
    assign updIr = ctl.tckFall && ctl.state == TAP_UPD_IR;
    assign capDr = ctl.tckRise && ctl.state == TAP_CAP_DR;
    assign shDr = ctl.tckRise && ctl.state == TAP_SH_DR;
    assign updDr = ctl.tckFall && ctl.state == TAP_UPD_DR;
    assign shifting = ctl.state == TAP_SH_IR || ctl.state == TAP_SH_DR;

    // Only the boundary chain is gated by path; identification and bypass registers see every capture and shift strobe
    assign bsrCap = capDr && path == PATH_BSR;
    assign bsrShift = shDr && path == PATH_BSR;
    assign bsrUpdate = updDr && path == PATH_BSR;

    // Data register whose low bit feeds the serial output
    always_comb begin
        pathData = 1'b0;
        unique case (path)
            PATH_BSR: pathData = bsrSer;
            PATH_ID: pathData = idShift_q[0];
            PATH_BYP: pathData = bypass_q;
        endcase
    end

    bsid_boundary #(
        .N_OUT(N_OUT),
        .N_IN(N_IN)
    ) u_bsr (
        .clk(clk),
        .arst_n(arst_n),
        .capture(bsrCap),
        .shift(bsrShift),
        .update(bsrUpdate),
        .serIn(ctl.tdi),
        .pinIn(pinSync2_q),
        .coreOut(coreOut),
        .serOut(bsrSer),
        .updVal(bsrUpd)
    );

    // Instruction group
    always_comb begin
        irShift_d = irShift_q;
        irLatch_d = irLatch_q;
        if (capIr) begin
            irShift_d = IR_CAPTURE; // R12
        end else if (shIr) begin
            irShift_d = {ctl.tdi, irShift_q[IR_WIDTH-1:1]}; // R2
        end
        // Previous instruction stays in force until Update-IR or Test-Logic-Reset
        if (ctl.state == TAP_RESET) begin
            irLatch_d = OP_IDCODE; // R6
        end else if (updIr) begin
            irLatch_d = irShift_q; // R13
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irShift_q <= IR_CAPTURE;
            irLatch_q <= OP_IDCODE;
        end else begin
            irShift_q <= irShift_d;
            irLatch_q <= irLatch_d;
        end
    end

    // Identification and bypass group
    always_comb begin
        idShift_d = idShift_q;
        bypass_d = bypass_q;
        if (capDr) begin
            bypass_d = 1'b0; // R11
            idShift_d = idValue; // R5
        end else if (shDr) begin
            bypass_d = ctl.tdi; // R10
            idShift_d = {ctl.tdi, idShift_q[ID_WIDTH-1:1]};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idShift_q <= '0;
            bypass_q <= 1'b0;
        end else begin
            idShift_q <= idShift_d;
            bypass_q <= bypass_d;
        end
    end

    // Serial output group
    always_comb begin
        tdo_d = tdo_q;
        tdoOe_d = tdoOe_q;
        // Output changes on falling edge, as shift states are in force
        if (ctl.tckFall) begin
            tdoOe_d = shifting;
            tdo_d = (ctl.state == TAP_SH_IR) ? irShift_q[0] : pathData;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tdo_q <= 1'b0;
            tdoOe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            tdoOe_q <= tdoOe_d;
        end
    end

    // Pin muxing; registered so the top drives from flip-flops
    always_comb begin
        if (highz) begin
            pinOut_d = coreOut;
            pinOe_d = '0; // R9
        end else if (extest) begin
            pinOut_d = bsrUpd; // R4
            pinOe_d = '1; // R3
        end else begin
            pinOut_d = coreOut;
            pinOe_d = coreOe;
        end
        // Under external test the core sees zeros, not pins
        coreIn_d = extest ? '0 : pinSync2_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinOut_q <= '0;
            pinOe_q <= '0;
            coreIn_q <= '0;
        end else begin
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
            coreIn_q <= coreIn_d;
        end
    end

    // Pin inputs are asynchronous; only the second stage is read
    always_comb begin
        pinSync1_d = pinIn;
        pinSync2_d = pinSync1_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinSync1_q <= '0;
            pinSync2_q <= '0;
        end else begin
            pinSync1_q <= pinSync1_d;
            pinSync2_q <= pinSync2_d;
        end
    end

    assign tdo = tdo_q;
    assign tdoOe = tdoOe_q;
    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign coreIn = coreIn_q;
    assign curInstr = irLatch_q;
endmodule : bsid_scan_top

// ===== testbench/bsid_scan_chk.sv
// Port-level checks for the boundary-scan decode block
`timescale 1ns/10ps
module bsid_scan_chk #(
    parameter int N_OUT = 8,
    parameter int N_IN = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic [N_IN-1:0] pinIn,
    input wire logic [N_OUT-1:0] coreOut,
    input wire logic [N_OUT-1:0] coreOe,
    input wire logic tdo,
    input wire logic tdoOe,
    input wire logic [N_OUT-1:0] pinOut,
    input wire logic [N_OUT-1:0] pinOe,
    input wire logic [N_IN-1:0] coreIn,
    input wire logic [bsid_pkg::IR_WIDTH-1:0] curInstr
);
    import bsid_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic tckPrev_q;
    logic [3:0] sinceFall_q;
    logic normal;
    assign normal = curInstr != OP_EXTEST && curInstr != OP_HIGHZ;
    // Cycles since the test clock pin fell; rise-driven work lands later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tckPrev_q <= 1'b0;
            sinceFall_q <= 4'hF;
        end else begin
            tckPrev_q <= tck;
            if (tckPrev_q && !tck) sinceFall_q <= 4'h0;
            else if (sinceFall_q != 4'hF) sinceFall_q <= sinceFall_q + 4'h1;
        end
    end
    hiz_float_a: assert property (
        (curInstr == OP_HIGHZ)[*2] |-> pinOe == '0)
        else $error("pins not floated");
    extest_drive_a: assert property (
        (curInstr == OP_EXTEST)[*2] |-> pinOe == '1)
        else $error("pins not driven in external test");
    extest_core_a: assert property (
        (curInstr == OP_EXTEST)[*2] |-> coreIn == '0)
        else $error("core not isolated");
    normal_pass_a: assert property (normal[*2] |->
        pinOut == $past(coreOut) && pinOe == $past(coreOe))
        else $error("function disturbed");
    normal_core_a: assert property (
        (normal && $stable(pinIn))[*5] |-> coreIn == pinIn)
        else $error("pin inputs not passed");
    instr_update_a: assert property ($changed(curInstr) &&
        curInstr != OP_IDCODE |-> sinceFall_q <= 4'h4)
        else $error("instruction changed off a falling edge");
    tdo_shift_a: assert property (
        $changed(tdo) |-> sinceFall_q <= 4'h4)
        else $error("serial out moved off a falling edge");
    tdo_enable_a: assert property (
        $changed(tdoOe) |-> sinceFall_q <= 4'h4)
        else $error("serial enable moved off a falling edge");
    ident_reset_a: assert property (
        (!trst_n)[*8] |-> curInstr == OP_IDCODE)
        else $error("reset did not select identification");
    extest_pins_a: assert property (curInstr == OP_EXTEST &&
        $past(curInstr) == OP_EXTEST && $changed(pinOut) |-> sinceFall_q <= 4'h5)
        else $error("test pins moved without update");
endmodule : bsid_scan_chk

// ===== testbench/bsid_tap_host.sv
// Test controller model driving the TAP pins
`timescale 1ns/10ps
module bsid_tap_host (
    input wire logic clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo,
    input wire logic tdoOe
);
    initial {tck, tms, tdi, trst_n} = 4'b0111;
    // One 32 ns period; caller enters on a falling clk, tdo read mid-high
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (2) @(negedge clk);
        // Released line reads as the inverse, so a missing enable shows
        q = tdoOe ? tdo : ~tdo;
        repeat (2) @(negedge clk);
        tck = 1'b0;
    endtask : step
    task automatic tms_reset();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : tms_reset
    task automatic pin_reset();
        logic q;
        trst_n = 1'b0;
        repeat (10) @(negedge clk);
        trst_n = 1'b1;
        repeat (4) @(negedge clk);
        step(1'b0, 1'b1, q);
    endtask : pin_reset
    // Idle to idle, LSB first; tdi idles high like a pulled-up line
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : scan
endmodule : bsid_tap_host

// ===== testbench/tb_boundary_scan_instruction_decode.sv
// Self-checking bench for the boundary-scan decode block
`timescale 1ns/10ps
module tb_boundary_scan_instruction_decode;
    import bsid_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic tck, tms, tdi, trst_n, tdo, tdoOe;
    logic [7:0] coreOut = 8'h3C;
    logic [7:0] coreOe = 8'hC3;
    logic [7:0] pinIn = 8'hA5;
    logic [7:0] pinOut, pinOe, coreIn;
    logic [3:0] curInstr;
    logic [31:0] idVal = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    bsid_scan_top DUT (.clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n), .coreOut(coreOut), .coreOe(coreOe),
        .pinIn(pinIn), .tdo(tdo), .tdoOe(tdoOe), .pinOut(pinOut),
        .pinOe(pinOe), .coreIn(coreIn), .curInstr(curInstr));
    bsid_tap_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdoOe(tdoOe));
    always #2 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    // Whole run needs about 4200 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk
    task automatic t_ident();
        logic [31:0] d;
        chk("instr", 32'(OP_IDCODE), 32'(curInstr));
        coreOut = 8'h69;
        host.scan(1'b0, 32, 32'h0, d);
        chk("ident", idVal, d);
        chk("pinOut", 32'h69, 32'(pinOut));
        coreOut = 8'h3C;
    endtask : t_ident
    task automatic t_bypass(input logic [3:0] op);
        logic [31:0] d;
        logic [7:0] oe;
        host.scan(1'b1, 4, 32'(op), d);
        chk("irCapture", 32'h1, 32'(d[1:0]));
        chk("instr", 32'(op), 32'(curInstr));
        host.scan(1'b0, 8, 32'h5A, d);
        chk("bypass", 32'hB4, d);
        oe = (op == OP_HIGHZ) ? 8'h00 : coreOe;
        chk("pinOe", 32'(oe), 32'(pinOe));
    endtask : t_bypass
    task automatic t_boundary();
        logic [31:0] d;
        host.scan(1'b1, 4, 32'(OP_SAMPLE), d);
        host.scan(1'b0, 16, 32'h9600, d);
        chk("sample", 32'h3CA5, d);
        chk("coreIn", 32'hA5, 32'(coreIn));
        host.scan(1'b1, 4, 32'(OP_EXTEST), d);
        chk("preload", 32'h96, 32'(pinOut));
        chk("pinOe", 32'hFF, 32'(pinOe));
        chk("coreIn", 32'h0, 32'(coreIn));
        pinIn = 8'h5B;
        host.scan(1'b0, 16, 32'h0, d);
        chk("extCapture", 32'h5B, 32'(d[7:0]));
        chk("update", 32'h0, 32'(pinOut));
    endtask : t_boundary
    task automatic t_resets();
        logic [31:0] d;
        host.scan(1'b1, 4, 32'(OP_BYPASS), d);
        host.scan(1'b1, 4, 32'(OP_IDCODE), d);
        chk("instrLoad", 32'(OP_IDCODE), 32'(curInstr));
        host.scan(1'b0, 32, 32'h0, d);
        chk("identLoad", idVal, d);
        host.scan(1'b1, 4, 32'(OP_BYPASS), d);
        host.tms_reset();
        chk("tmsReset", 32'(OP_IDCODE), 32'(curInstr));
        host.scan(1'b1, 4, 32'(OP_HIGHZ), d);
        host.pin_reset();
        chk("pinReset", 32'(OP_IDCODE), 32'(curInstr));
        host.scan(1'b0, 32, 32'h0, d);
        chk("identAgain", idVal, d);
    endtask : t_resets
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        host.tms_reset();
        t_ident();
        for (int i = 3; i < 16; i++) t_bypass(4'(i));
        t_boundary();
        t_resets();
        tally_and_finish();
    end
endmodule : tb_boundary_scan_instruction_decode
bind bsid_scan_top bsid_scan_chk #(.N_OUT(N_OUT), .N_IN(N_IN)) chk (
    .clk(clk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n), .pinIn(pinIn),
    .coreOut(coreOut), .coreOe(coreOe), .tdo(tdo), .tdoOe(tdoOe),
    .pinOut(pinOut),
    .pinOe(pinOe), .coreIn(coreIn), .curInstr(curInstr));
